// *** design/res_regs.svh ***
// register offsets, field positions, reset values and timing counts for rail enable sequencing
`ifndef RES_REGS_SVH
`define RES_REGS_SVH

// register offsets
`define RES_OFF_EDGE_DLY 8'h15
`define RES_OFF_GOOD_MASK 8'h16
`define RES_OFF_SIX_CTL 8'h17
`define RES_OFF_STATUS 8'h1C
`define RES_OFF_GOOD_LO 8'h1D
`define RES_OFF_GOOD_HI 8'h1E

// writable bits per register
`define RES_WMASK_EDGE_DLY 8'h3F
`define RES_WMASK_GOOD_MASK 8'hFF
`define RES_WMASK_SIX_CTL 8'h3F

// reset values
`define RES_RST_EDGE_DLY 8'h00
`define RES_RST_GOOD_MASK 8'h00
`define RES_RST_SIX_CTL 8'h00

// status bit positions
`define RES_ST_FIVE_EN 0
`define RES_ST_SIX_EN 1
`define RES_ST_SRC_ACTIVE 2
`define RES_ST_GOOD_OK 3
`define RES_ST_FIVE_BUSY 4
`define RES_ST_FIVE_PIN 5

// power_good input positions
`define RES_PG_SHARED 8
`define RES_PG_SWITCH_B 9
`define RES_NUM_PG 10
`define RES_NUM_CTL 6

// delay figures in ms
`define RES_DLY_MS_0 0
`define RES_DLY_MS_1 2
`define RES_DLY_MS_2 4
`define RES_DLY_MS_3 8
`define RES_DLY_MS_4 16
`define RES_DLY_MS_5 24
`define RES_DLY_MS_6 32
`define RES_DLY_MS_7 64

// timing
`define RES_CLK_HZ 125000000
`define RES_MS_PER_S 1000
`define RES_CYC_PER_MS (`RES_CLK_HZ / `RES_MS_PER_S)
`define RES_CNT_W 24

`endif

// *** design/res_pkg.sv ***
// types shared by the rail enable sequencing block
package res_pkg;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] off_code;
    logic [2:0] on_code;
  } res_edge_dly_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic voltage_step;
    logic [2:0] enable_source;
    logic mask_shared_switch;
    logic mask_switch_b;
  } res_six_ctl_t;

  typedef enum logic [2:0] {
    RES_SRC_CONTROL_INPUT_ONE,
    RES_SRC_CONTROL_INPUT_TWO,
    RES_SRC_CONTROL_INPUT_FIVE,
    RES_SRC_CONTROL_INPUT_FOUR,
    RES_SRC_CONTROL_INPUT_THREE,
    RES_SRC_CONTROL_INPUT_THREE_CONTROL_INPUT_FOUR,
    RES_SRC_CONTROL_INPUT_SIX,
    RES_SRC_ALWAYS
  } res_src_t;

  typedef enum logic {
    RES_ST_STEADY,
    RES_ST_WAIT
  } res_dly_state_t;

endpackage

// *** design/res_edge_delay.sv ***
// delays the rising and falling edges of one enable level by programmable times
`timescale 1ns/10ps
`include "res_regs.svh"

module res_edge_delay
  import res_pkg::*;
#(
  parameter int unsigned P_CYC_PER_MS = `RES_CYC_PER_MS,
  parameter int unsigned P_CNT_W = `RES_CNT_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // enable level and delay codes
  input wire logic i_level,
  input wire logic [2:0] i_on_code,
  input wire logic [2:0] i_off_code,
  // delayed level
  output logic o_level,
  output logic o_busy
);

  function automatic logic [6:0] dly_ms(input logic [2:0] code);
    logic [6:0] ms;
    ms = 7'(`RES_DLY_MS_0);
    case (code)
      3'h1: ms = 7'(`RES_DLY_MS_1);
      3'h2: ms = 7'(`RES_DLY_MS_2);
      3'h3: ms = 7'(`RES_DLY_MS_3);
      3'h4: ms = 7'(`RES_DLY_MS_4);
      3'h5: ms = 7'(`RES_DLY_MS_5);
      3'h6: ms = 7'(`RES_DLY_MS_6);
      3'h7: ms = 7'(`RES_DLY_MS_7);
      default: ms = 7'(`RES_DLY_MS_0);
    endcase
    return ms;
  endfunction

  res_dly_state_t state;
  logic [P_CNT_W-1:0] cnt;
  wire logic pending;
  wire logic [2:0] code;
  wire logic [P_CNT_W-1:0] target;
  wire logic [P_CNT_W-1:0] cnt_inc;
  wire logic expire;

  // rising edge uses the on code, falling edge the off code
  assign pending = i_level != o_level;
  assign code = i_level ? i_on_code : i_off_code;
  // nominal time only; the allowed spread is left for checks to absorb
  assign target = P_CNT_W'(32'(dly_ms(code)) * P_CYC_PER_MS);
  assign cnt_inc = cnt + P_CNT_W'(1);
  assign expire = cnt_inc >= target;

  // a level that reverts before expiry cancels the pending edge
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= RES_ST_STEADY;
      cnt <= '0;
      o_level <= 1'b0;
    end else if (!pending || expire) begin
      state <= RES_ST_STEADY;
      cnt <= '0;
      o_level <= i_level;
    end else begin
      state <= RES_ST_WAIT;
      cnt <= cnt_inc;
    end
  end

  assign o_busy = state == RES_ST_WAIT;

endmodule

// *** design/res_rail_seq.sv ***
// enable sequencing control for step-down rails five and six with register port
`timescale 1ns/10ps
`include "res_regs.svh"

module res_rail_seq
  import res_pkg::*;
#(
  parameter int unsigned P_CYC_PER_MS = `RES_CYC_PER_MS,
  parameter int unsigned P_CNT_W = `RES_CNT_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // control inputs and rail five enable pin
  input wire logic [`RES_NUM_CTL-1:0] i_ctl,
  input wire logic i_rail_five_en_pin,
  // power_good inputs of the other rails
  input wire logic [`RES_NUM_PG-1:0] i_power_good,
  // rail controls
  output logic o_rail_five_en,
  output logic o_rail_six_en,
  output logic o_rail_six_voltage_step
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------

  localparam int unsigned NUM_SYNC = `RES_NUM_CTL + `RES_NUM_PG + 1;

  wire logic [NUM_SYNC-1:0] sync_in;
  logic [NUM_SYNC-1:0] sync_q;

  assign sync_in = {i_rail_five_en_pin, i_power_good, i_ctl};

  // a change is taken only once the second and third stages agree
  generate
    for (genvar gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      wire logic next_q;

      assign next_q = (s2 == s3) ? s3 : sync_q[gi];

      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          s1 <= sync_in[gi];
          s2 <= s1;
          s3 <= s2;
          sync_q[gi] <= next_q;
        end
      end
    end
  endgenerate

  wire logic [`RES_NUM_CTL-1:0] ctl_q;
  wire logic [`RES_NUM_PG-1:0] good_q;
  wire logic five_pin_q;

  assign ctl_q = sync_q[`RES_NUM_CTL-1:0];
  assign good_q = sync_q[`RES_NUM_CTL+`RES_NUM_PG-1:`RES_NUM_CTL];
  assign five_pin_q = sync_q[NUM_SYNC-1];

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------

  wire logic hit_edge_dly;
  wire logic hit_good_mask;
  wire logic hit_six_ctl;
  wire logic hit_status;
  wire logic hit_good_lo;
  wire logic hit_good_hi;
  wire logic wr_edge_dly;
  wire logic wr_good_mask;
  wire logic wr_six_ctl;

  assign hit_edge_dly = i_reg_addr == `RES_OFF_EDGE_DLY;
  assign hit_good_mask = i_reg_addr == `RES_OFF_GOOD_MASK;
  assign hit_six_ctl = i_reg_addr == `RES_OFF_SIX_CTL;
  assign hit_status = i_reg_addr == `RES_OFF_STATUS;
  assign hit_good_lo = i_reg_addr == `RES_OFF_GOOD_LO;
  assign hit_good_hi = i_reg_addr == `RES_OFF_GOOD_HI;

  assign wr_edge_dly = i_reg_wr & hit_edge_dly;
  assign wr_good_mask = i_reg_wr & hit_good_mask;
  assign wr_six_ctl = i_reg_wr & hit_six_ctl;

  // ------------------------------------------------------------
  // register write data
  // ------------------------------------------------------------

  wire logic [7:0] wdata_edge_dly;
  wire logic [7:0] wdata_good_mask;
  wire logic [7:0] wdata_six_ctl;

  // reserved-bit masks applied once, ahead of the register loads
  assign wdata_edge_dly = i_reg_wdata & `RES_WMASK_EDGE_DLY;
  assign wdata_good_mask = i_reg_wdata & `RES_WMASK_GOOD_MASK;
  assign wdata_six_ctl = i_reg_wdata & `RES_WMASK_SIX_CTL;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------

  res_edge_dly_t rail_five_edge_delays;
  logic [7:0] rail_six_good_mask_low;
  res_six_ctl_t rail_six_source_and_mask;

  wire res_edge_dly_t next_rail_five_edge_delays;
  wire logic [7:0] next_rail_six_good_mask_low;
  wire res_six_ctl_t next_rail_six_source_and_mask;

  // reserved bits never store, so they read back as zero
  assign next_rail_five_edge_delays = wr_edge_dly
    ? res_edge_dly_t'(wdata_edge_dly)
    : rail_five_edge_delays;

  assign next_rail_six_good_mask_low = wr_good_mask
    ? wdata_good_mask
    : rail_six_good_mask_low;

  // step bit is writable; keeping it constant at run time is up to software
  assign next_rail_six_source_and_mask = wr_six_ctl
    ? res_six_ctl_t'(wdata_six_ctl)
    : rail_six_source_and_mask;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rail_five_edge_delays <= res_edge_dly_t'(`RES_RST_EDGE_DLY);
    end else begin
      rail_five_edge_delays <= next_rail_five_edge_delays;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rail_six_good_mask_low <= `RES_RST_GOOD_MASK;
    end else begin
      rail_six_good_mask_low <= next_rail_six_good_mask_low;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rail_six_source_and_mask <= res_six_ctl_t'(`RES_RST_SIX_CTL);
    end else begin
      rail_six_source_and_mask <= next_rail_six_source_and_mask;
    end
  end

  // ------------------------------------------------------------
  // register field views
  // ------------------------------------------------------------

  // rail five delay codes
  wire logic [2:0] five_on_code;
  wire logic [2:0] five_off_code;

  assign five_on_code = rail_five_edge_delays.on_code;
  assign five_off_code = rail_five_edge_delays.off_code;

  // rail six source, masks and step
  wire logic [2:0] six_source_code;
  wire logic six_mask_shared;
  wire logic six_mask_switch_b;
  wire logic six_step;

  assign six_source_code = rail_six_source_and_mask.enable_source;
  assign six_mask_shared = rail_six_source_and_mask.mask_shared_switch;
  assign six_mask_switch_b = rail_six_source_and_mask.mask_switch_b;
  assign six_step = rail_six_source_and_mask.voltage_step;

  // ------------------------------------------------------------
  // rail five edge delays
  // ------------------------------------------------------------

  wire logic five_level;
  wire logic five_busy;

  res_edge_delay #(
    .P_CYC_PER_MS(P_CYC_PER_MS),
    .P_CNT_W(P_CNT_W)
  ) u_five_delay (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_level(five_pin_q),
    .i_on_code(five_on_code),
    .i_off_code(five_off_code),
    .o_level(five_level),
    .o_busy(five_busy)
  );

  // extra flop keeps the top output straight from a register
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rail_five_en <= 1'b0;
    end else begin
      o_rail_five_en <= five_level;
    end
  end

  // ------------------------------------------------------------
  // rail six enable source
  // ------------------------------------------------------------

  wire logic [7:0] src_vec;
  wire res_src_t src_sel;
  wire logic src_active;

  // entry order follows the source encoding; top entry is the constant one
  assign src_vec[RES_SRC_CONTROL_INPUT_ONE] = ctl_q[0];
  assign src_vec[RES_SRC_CONTROL_INPUT_TWO] = ctl_q[1];
  assign src_vec[RES_SRC_CONTROL_INPUT_FIVE] = ctl_q[4];
  assign src_vec[RES_SRC_CONTROL_INPUT_FOUR] = ctl_q[3];
  assign src_vec[RES_SRC_CONTROL_INPUT_THREE] = ctl_q[2];
  assign src_vec[RES_SRC_CONTROL_INPUT_THREE_CONTROL_INPUT_FOUR] = ctl_q[2] & ctl_q[3];
  assign src_vec[RES_SRC_CONTROL_INPUT_SIX] = ctl_q[5];
  assign src_vec[RES_SRC_ALWAYS] = 1'b1;

  assign src_sel = res_src_t'(six_source_code);
  assign src_active = src_vec[src_sel];

  // ------------------------------------------------------------
  // rail six power_good gating
  // ------------------------------------------------------------

  wire logic [`RES_NUM_PG-1:0] good_mask;
  wire logic [`RES_NUM_PG-1:0] good_pass;
  wire logic good_ok;
  wire logic next_rail_six_en;

  // a set mask bit forces its power_good term true
  assign good_mask[7:0] = rail_six_good_mask_low;
  assign good_mask[`RES_PG_SHARED] = six_mask_shared;
  assign good_mask[`RES_PG_SWITCH_B] = six_mask_switch_b;
  assign good_pass = good_q | good_mask;
  assign good_ok = &good_pass;
  assign next_rail_six_en = src_active & good_ok;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rail_six_en <= 1'b0;
    end else begin
      o_rail_six_en <= next_rail_six_en;
    end
  end

  // ------------------------------------------------------------
  // rail six voltage step
  // ------------------------------------------------------------

  // high selects 25 mV steps, low 10 mV
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rail_six_voltage_step <= 1'b0;
    end else begin
      o_rail_six_voltage_step <= six_step;
    end
  end

  // ------------------------------------------------------------
  // configuration read words
  // ------------------------------------------------------------

  wire logic [7:0] edge_dly_word;
  wire logic [7:0] good_mask_word;
  wire logic [7:0] six_ctl_word;

  // packed structs flattened to plain bytes, so the read mux sees one type
  assign edge_dly_word = 8'(rail_five_edge_delays);
  assign good_mask_word = rail_six_good_mask_low;
  assign six_ctl_word = 8'(rail_six_source_and_mask);

  // ------------------------------------------------------------
  // status and read back
  // ------------------------------------------------------------

  wire logic [7:0] status_word;
  wire logic [7:0] good_lo_word;
  wire logic [7:0] good_hi_word;
  wire logic [7:0] rd_mux;
  wire logic [7:0] next_rdata;

  assign status_word[`RES_ST_FIVE_EN] = o_rail_five_en;
  assign status_word[`RES_ST_SIX_EN] = o_rail_six_en;
  assign status_word[`RES_ST_SRC_ACTIVE] = src_active;
  assign status_word[`RES_ST_GOOD_OK] = good_ok;
  assign status_word[`RES_ST_FIVE_BUSY] = five_busy;
  assign status_word[`RES_ST_FIVE_PIN] = five_pin_q;
  assign status_word[7:6] = 2'h0;

  assign good_lo_word = good_q[7:0];
  assign good_hi_word = {6'h00, good_q[`RES_PG_SWITCH_B:`RES_PG_SHARED]};

  // unmapped offsets read as zero
  assign rd_mux = hit_edge_dly ? edge_dly_word
    : hit_good_mask ? good_mask_word
    : hit_six_ctl ? six_ctl_word
    : hit_status ? status_word
    : hit_good_lo ? good_lo_word
    : hit_good_hi ? good_hi_word
    : 8'h00;

  // data stand for exactly one cycle after the strobe
  assign next_rdata = i_reg_rd ? rd_mux : 8'h00;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

endmodule

// *** testbench/res_rail_seq_chk.sv ***
// port assertions for the rail enable sequencing block
`timescale 1ns/10ps
`include "res_regs.svh"

module res_rail_seq_chk #(
  parameter int unsigned P_CYC_PER_MS = `RES_CYC_PER_MS
) (
  // clock, reset and register port
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // pins and rail controls
  input wire logic [`RES_NUM_CTL-1:0] i_ctl,
  input wire logic i_rail_five_en_pin,
  input wire logic [`RES_NUM_PG-1:0] i_power_good,
  input wire logic o_rail_five_en,
  input wire logic o_rail_six_en,
  input wire logic o_rail_six_voltage_step
);
  localparam int unsigned MS_TAB [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic [7:0] dly_sh;
  logic [7:0] mask_sh;
  logic [7:0] six_sh;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  int unsigned on_t;
  int unsigned off_t;
  assign on_t = MS_TAB[dly_sh[2:0]] * P_CYC_PER_MS;
  assign off_t = MS_TAB[dly_sh[5:3]] * P_CYC_PER_MS;

  // ----------------------------------------
  // shadow registers and pin level age
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dly_sh <= 8'h00;
      mask_sh <= 8'h00;
      six_sh <= 8'h00;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `RES_OFF_EDGE_DLY) dly_sh <= i_reg_wdata & 8'h3F;
      if (i_reg_addr == `RES_OFF_GOOD_MASK) mask_sh <= i_reg_wdata;
      if (i_reg_addr == `RES_OFF_SIX_CTL) six_sh <= i_reg_wdata & 8'h3F;
    end
  end

  // saturating, so a long idle level never wraps into a false short one
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
    end else begin
      hi_cnt <= i_rail_five_en_pin ? hi_cnt + 16'(hi_cnt != 16'hFFFF) : 16'h0000;
      lo_cnt <= !i_rail_five_en_pin ? lo_cnt + 16'(lo_cnt != 16'hFFFF) : 16'h0000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_read_delays: assert property (i_reg_rd && i_reg_addr == `RES_OFF_EDGE_DLY |=> o_reg_rdata == dly_sh)
    else $error("delay register readback wrong");
  a_read_mask: assert property (i_reg_rd && i_reg_addr == `RES_OFF_GOOD_MASK |=> o_reg_rdata == mask_sh)
    else $error("mask register readback wrong");
  a_read_six: assert property (i_reg_rd && i_reg_addr == `RES_OFF_SIX_CTL |=> o_reg_rdata == six_sh)
    else $error("rail six control readback wrong");
  a_step_copy: assert property (i_reg_wr && i_reg_addr == `RES_OFF_SIX_CTL
    |-> ##2 o_rail_six_voltage_step == $past(i_reg_wdata[5], 2))
    else $error("step output not following register");
  a_six_always: assert property ((six_sh[4:0] == 5'h1F && mask_sh == 8'hFF)[*3] |-> o_rail_six_en)
    else $error("constant source did not enable rail six");
  a_six_no_src: assert property ((i_ctl == 6'h00 && six_sh[4:2] != 3'h7)[*8] |-> !o_rail_six_en)
    else $error("rail six on without source");
  a_six_pg_block: assert property ((i_power_good == 10'h000 && mask_sh != 8'hFF)[*8] |-> !o_rail_six_en)
    else $error("rail six on with unmasked power_good low");
  a_five_zero_dly: assert property ((dly_sh == 8'h00 && $stable(i_rail_five_en_pin))[*8]
    |-> o_rail_five_en == i_rail_five_en_pin)
    else $error("rail five not following pin");
  a_five_on_time: assert property ($rose(o_rail_five_en)
    |-> hi_cnt >= on_t * 9 / 10 && hi_cnt <= on_t * 11 / 10 + 10)
    else $error("rail five turn-on delay out of range");
  a_five_off_time: assert property ($fell(o_rail_five_en)
    |-> lo_cnt >= off_t * 9 / 10 && lo_cnt <= off_t * 11 / 10 + 10)
    else $error("rail five turn-off delay out of range");

  c_six_on: cover property ($rose(o_rail_six_en));
  c_five_on_long: cover property ($rose(o_rail_five_en) && on_t > 0);
  c_five_off_long: cover property ($fell(o_rail_five_en) && off_t > 0);
endmodule

bind res_rail_seq res_rail_seq_chk #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_ctl(i_ctl),
  .i_rail_five_en_pin(i_rail_five_en_pin), .i_power_good(i_power_good), .o_rail_five_en(o_rail_five_en),
  .o_rail_six_en(o_rail_six_en), .o_rail_six_voltage_step(o_rail_six_voltage_step));

// *** testbench/res_ctl_model.sv ***
// system logic model driving control inputs, power_good levels and the rail five pin
`timescale 1ns/10ps

module res_ctl_model (
  // clock and pace
  input wire logic i_clk_sys,
  input wire logic i_slow,
  // requested levels
  input wire logic [5:0] i_ctl_req,
  input wire logic [9:0] i_pg_req,
  input wire logic i_pin_req,
  // pin levels
  output logic [5:0] o_ctl,
  output logic [9:0] o_power_good,
  output logic o_pin
);
  // slow mode lags every level four cycles, three more than fast mode, like a late supervisor
  logic [16:0] pipe [3];
  always @(posedge i_clk_sys) begin
    pipe[0] <= {i_ctl_req, i_pg_req, i_pin_req};
    pipe[1] <= pipe[0];
    pipe[2] <= pipe[1];
    {o_ctl, o_power_good, o_pin} <= i_slow ? pipe[2] : {i_ctl_req, i_pg_req, i_pin_req};
  end
endmodule

// *** testbench/res_rail_seq_tb_top.sv ***
// testbench for the rail enable sequencing block
`timescale 1ns/10ps

module res_rail_seq_tb_top;
  localparam int unsigned P_MS = 10;
  localparam int unsigned MS_TAB [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  localparam logic [5:0] SRC_ON [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [5:0] ctl_req = 6'h00;
  logic [9:0] pg_req = 10'h000;
  logic pin_req = 1'b0;
  logic [5:0] ctl;
  logic [9:0] pg;
  logic pin;
  logic [7:0] rdata;
  logic five_en;
  logic six_en;
  logic step;
  logic [1:0] m;
  int err_total = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  res_rail_seq #(.P_CYC_PER_MS(P_MS)) dut (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_ctl(ctl), .i_rail_five_en_pin(pin), .i_power_good(pg),
    .o_rail_five_en(five_en), .o_rail_six_en(six_en), .o_rail_six_voltage_step(step));
  res_ctl_model u_sys (.i_clk_sys(clk), .i_slow(slow), .i_ctl_req(ctl_req), .i_pg_req(pg_req),
    .i_pin_req(pin_req), .o_ctl(ctl), .o_power_good(pg), .o_pin(pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(name, {8'h00, rdata}, {8'h00, exp});
  endtask

  // long enough for the slow partner plus the pin synchronisers
  task automatic pins(input logic [5:0] c, input logic [9:0] p);
    @(posedge clk);
    ctl_req <= c;
    pg_req <= p;
    repeat (16) @(posedge clk);
    #1;
  endtask

  task automatic edge_time(input logic lvl, input int unsigned ms, input string name);
    int unsigned n;
    n = 0;
    @(posedge clk);
    pin_req <= lvl;
    while (five_en !== lvl && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 1000) begin
      err_total++;
      print_verdict();
    end else begin
      check(name, 16'(n >= ms * P_MS * 9 / 10 && n <= ms * P_MS * 11 / 10 + 12), 16'h0001);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("step_rst", step, 16'h0000);
    reg_rd(8'h15, 8'h00, "dly_rst");
    reg_rd(8'h16, 8'h00, "mask_rst");
    reg_rd(8'h17, 8'h00, "six_rst");
    reg_wr(8'h15, 8'hFF);
    reg_rd(8'h15, 8'h3F, "dly_rsvd");
    reg_wr(8'h16, 8'hA5);
    reg_rd(8'h16, 8'hA5, "mask_rw");
    reg_wr(8'h40, 8'h5A);
    reg_rd(8'h40, 8'h00, "unmapped");
    reg_wr(8'h16, 8'hFF);
    // step picked once here at configuration and kept in every later write
    reg_wr(8'h17, 8'hFF);
    reg_rd(8'h17, 8'h3F, "six_rsvd");
    check("step_set", step, 16'h0001);
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      reg_wr(8'h17, {3'b001, 3'(s), 2'b11});
      pins(SRC_ON[s], 10'h3FF);
      check("src_on", six_en, 16'h0001);
      pins(~SRC_ON[s], 10'h3FF);
      check("src_off", six_en, 16'(s == 7));
    end
    reg_wr(8'h17, 8'h37);
    pins(6'h04, 10'h3FF);
    check("pair_half", six_en, 16'h0000);
    reg_rd(8'h1C, 8'h08, "status");
    reg_rd(8'h1D, 8'hFF, "good_lo");
    reg_rd(8'h1E, 8'h03, "good_hi");
    $display("test sources done");
    @(posedge clk);
    slow <= 1'b1;
    for (int b = 0; b < 10; b++) begin
      m = (b == 8) ? 2'b01 : (b == 9) ? 2'b10 : 2'b11;
      reg_wr(8'h16, ~(8'h01 << b));
      reg_wr(8'h17, {6'b001111, m});
      pins(6'h00, ~(10'h001 << b));
      check("pg_block", six_en, 16'h0000);
      pins(6'h00, ~(10'h001 << ((b + 1) % 10)));
      check("pg_masked", six_en, 16'h0001);
    end
    reg_wr(8'h16, 8'h00);
    pins(6'h00, 10'h000);
    check("pg_all_low", six_en, 16'h0000);
    $display("test masks done");
    @(posedge clk);
    slow <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h15, {2'b00, 3'(7 - c), 3'(c)});
      edge_time(1'b1, MS_TAB[c], "on_delay");
      edge_time(1'b0, MS_TAB[7 - c], "off_delay");
    end
    // a pin pulse shorter than the turn-on delay must cancel the edge
    reg_wr(8'h15, 8'h01);
    @(posedge clk);
    pin_req <= 1'b1;
    repeat (8) @(posedge clk);
    pin_req <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    check("glitch", five_en, 16'h0000);
    check("step_hold", step, 16'h0001);
    $display("test delays done");
    print_verdict();
  end
endmodule
